// >>> hdl/zq_cal_pkg.sv
package zq_cal_pkg;

    // command encodings on the shared command lines
    typedef enum logic [2:0]
    {
        cmd_nop,
        cmd_zq_long,
        cmd_zq_short,
        cmd_precharge_all,
        cmd_self_refresh_enter,
        cmd_self_refresh_exit,
        cmd_other
    } zq_cmd_t;

    // calibration windows in clock cycles
    localparam int unsigned ZQ_INIT_CYCLES  = 1024;
    localparam int unsigned ZQ_OPER_CYCLES  = 512;
    localparam int unsigned ZQ_SHORT_CYCLES = 128;
    // engine convergence for a short calibration
    localparam int unsigned ZQ_CORRECT_CYCLES = 64;
    // precharge settle and self refresh exit delays
    localparam int unsigned PRECHARGE_CYCLES = 16;
    localparam int unsigned SELF_REFRESH_EXIT_CYCLES = 32;
    localparam int unsigned COUNT_WIDTH = 11;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 11'h000;

    // impedance code width and reset value
    localparam int unsigned CODE_WIDTH = 8;
    localparam logic [CODE_WIDTH-1:0] CODE_RESET = 8'h80;
    // parked termination field width and reset value
    localparam int unsigned PARK_WIDTH = 3;
    localparam logic [PARK_WIDTH-1:0] PARK_RESET = 3'h0;

    function automatic logic [COUNT_WIDTH-1:0] to_count(input int unsigned n);
        return n[COUNT_WIDTH-1:0];
    endfunction

endpackage

// >>> hdl/zq_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface zq_link_if;
    import zq_cal_pkg::*;
    zq_cmd_t cmd;
    logic    cke;
    logic    odt;
    logic    dq_out_en_ctrl;
    logic    dq_out_en_dev;
    logic    cal_busy;

    modport controller
    (
        output cmd,
        output cke,
        output odt,
        output dq_out_en_ctrl,
        input  dq_out_en_dev,
        input  cal_busy
    );

    modport device
    (
        input  cmd,
        input  cke,
        input  odt,
        input  dq_out_en_ctrl,
        output dq_out_en_dev,
        output cal_busy
    );
endinterface
`default_nettype wire

// >>> hdl/zq_cal_engine.sv
`timescale 1ns/1ps
`default_nettype none
module zq_cal_engine
    import zq_cal_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    // control
    input  wire logic                  start,
    input  wire logic [COUNT_WIDTH-1:0] run_cycles,
    input  wire logic [CODE_WIDTH-1:0] target_code,
    // results
    output logic                       running,
    output logic                       done,
    output logic [CODE_WIDTH-1:0]      code
);
    logic [COUNT_WIDTH-1:0] remaining;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            remaining <= COUNT_RESET;
        else if (start)
            remaining <= run_cycles;
        else if (remaining != COUNT_RESET)
            remaining <= remaining - 11'h001;
    end

    assign running = (remaining != COUNT_RESET);
    assign done    = (remaining == 11'h001);

    // successive approach toward the resistor reference, one step a cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            code <= CODE_RESET;
        else if (running && code < target_code)
            code <= code + 8'h01;
        else if (running && code > target_code)
            code <= code - 8'h01;
    end
endmodule
`default_nettype wire

// >>> hdl/zq_cal_device.sv
`timescale 1ns/1ps
`default_nettype none
module zq_cal_device
    import zq_cal_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    // link
    zq_link_if.device                  link,
    // configuration and analog reference
    input  wire logic [PARK_WIDTH-1:0] park_value,
    input  wire logic                  nominal_term_on,
    input  wire logic [CODE_WIDTH-1:0] reference_code,
    // status
    output logic [CODE_WIDTH-1:0]      io_code,
    output logic [PARK_WIDTH-1:0]      applied_term,
    output logic                       cal_current_on,
    output logic                       first_long_seen
);
    logic                   start;
    logic [COUNT_WIDTH-1:0] window;
    logic                   running;
    logic                   done;
    logic [CODE_WIDTH-1:0]  code;

    // only explicit commands start the engine; self refresh exit does not
    assign start = !running && (link.cmd == cmd_zq_long || link.cmd == cmd_zq_short);

    always_comb
    begin
        if (link.cmd == cmd_zq_short)
            window = to_count(ZQ_SHORT_CYCLES);
        else if (!first_long_seen)
            window = to_count(ZQ_INIT_CYCLES);
        else
            window = to_count(ZQ_OPER_CYCLES);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            first_long_seen <= 1'b0;
        else if (start && link.cmd == cmd_zq_long)
            first_long_seen <= 1'b1;
    end

    zq_cal_engine u_engine
    (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .start       (start),
        .run_cycles  (window),
        .target_code (reference_code),
        .running     (running),
        .done        (done),
        .code        (code)
    );

    // transfer of calibrated code to the drivers at completion
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            io_code <= CODE_RESET;
        else if (done)
            io_code <= code;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cal_current_on <= 1'b0;
        else
            cal_current_on <= start || (running && !done);
    end

    // parked termination while calibrating, nominal off or ODT low
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            applied_term <= PARK_RESET;
        else if (running || !nominal_term_on || !link.odt)
            applied_term <= park_value;
        else
            applied_term <= PARK_RESET;
    end

    assign link.cal_busy      = running;
    assign link.dq_out_en_dev = 1'b0;
endmodule
`default_nettype wire

// >>> hdl/zq_cal_controller.sv
`timescale 1ns/1ps
`default_nettype none
module zq_cal_controller
    import zq_cal_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // user requests
    input  wire logic req_long,
    input  wire logic req_short,
    input  wire logic req_precharge,
    input  wire logic req_sr_enter,
    input  wire logic req_sr_exit,
    input  wire logic req_other,
    // user status
    output logic      ready,
    output logic      calibrating,
    output logic      first_long_issued,
    // link
    zq_link_if.controller link
);
    typedef enum {st_idle, st_self_refresh, st_wait} ctrl_state_t;
    ctrl_state_t            state;
    logic [COUNT_WIDTH-1:0] wait_count;
    logic [COUNT_WIDTH-1:0] settle_count;
    logic                   precharged;
    logic                   settled;
    logic                   go_long;
    logic                   go_short;
    logic                   go_pre;
    logic                   go_other;
    logic                   go_sr;

    assign settled  = (settle_count == COUNT_RESET);
    assign ready    = (state == st_idle) && settled;
    assign go_long  = ready && req_long && precharged;
    assign go_short = ready && !req_long && req_short && precharged;
    assign go_pre   = ready && !req_long && !req_short && req_precharge;
    assign go_other = ready && !req_long && !req_short && !req_precharge && req_other;
    // self refresh entry only when no other request competes, so command and state agree
    assign go_sr    = ready && !req_long && !req_short && !req_precharge && !req_other && req_sr_enter;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            state <= st_idle;
        else
            unique case (state)
                st_idle:
                    if (go_long || go_short)
                        state <= st_wait;
                    else if (go_sr)
                        state <= st_self_refresh;
                st_self_refresh:
                    if (req_sr_exit)
                        state <= st_idle;
                st_wait:
                    if (wait_count == 11'h001)
                        state <= st_idle;
            endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            wait_count <= COUNT_RESET;
        else if (go_long && !first_long_issued)
            wait_count <= to_count(ZQ_INIT_CYCLES);
        else if (go_long)
            wait_count <= to_count(ZQ_OPER_CYCLES);
        else if (go_short)
            wait_count <= to_count(ZQ_SHORT_CYCLES);
        else if (wait_count != COUNT_RESET)
            wait_count <= wait_count - 11'h001;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            first_long_issued <= 1'b0;
        else if (go_long)
            first_long_issued <= 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            settle_count <= COUNT_RESET;
        else if (go_pre)
            settle_count <= to_count(PRECHARGE_CYCLES);
        else if (state == st_self_refresh && req_sr_exit)
            settle_count <= to_count(SELF_REFRESH_EXIT_CYCLES);
        else if (settle_count != COUNT_RESET)
            settle_count <= settle_count - 11'h001;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            precharged <= 1'b0;
        else if (go_pre)
            precharged <= 1'b1;
        else if (go_other)
            precharged <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            link.cmd <= cmd_nop;
        else if (go_long)
            link.cmd <= cmd_zq_long;
        else if (go_short)
            link.cmd <= cmd_zq_short;
        else if (go_pre)
            link.cmd <= cmd_precharge_all;
        else if (go_other)
            link.cmd <= cmd_other;
        else if (go_sr)
            link.cmd <= cmd_self_refresh_enter;
        else if (state == st_self_refresh && req_sr_exit)
            link.cmd <= cmd_self_refresh_exit;
        else
            link.cmd <= cmd_nop;
    end

    assign calibrating         = (state == st_wait);
    assign link.cke            = (state != st_self_refresh);
    assign link.odt            = 1'b0;
    assign link.dq_out_en_ctrl = 1'b0;
endmodule
`default_nettype wire

// >>> testbench/zq_cal_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module zq_cal_assertions
    import zq_cal_pkg::*;
(
    // clock and reset
    input wire logic    sys_clk,
    input wire logic    rstn,
    // link
    input wire zq_cmd_t cmd,
    input wire logic    cke,
    input wire logic    odt,
    input wire logic    dq_out_en_ctrl,
    input wire logic    dq_out_en_dev,
    input wire logic    cal_busy
);
    logic [10:0] blen;
    logic [1:0]  kind;
    logic        long_seen;
    logic [5:0]  since_exit;
    wire         zq_go = (cmd == cmd_zq_long || cmd == cmd_zq_short) && !cal_busy;

    // busy length, window kind, cycles since self refresh exit
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            blen <= 11'h000;
        else
            blen <= cal_busy ? blen + 11'h001 : 11'h000;
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            kind <= 2'h0;
        else if (zq_go)
            kind <= (cmd == cmd_zq_short) ? 2'h2 : {1'b0, long_seen};
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            long_seen <= 1'b0;
        else if (zq_go && cmd == cmd_zq_long)
            long_seen <= 1'b1;
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            since_exit <= 6'h3f;
        else if (cmd == cmd_self_refresh_exit)
            since_exit <= 6'h00;
        else if (since_exit != 6'h3f)
            since_exit <= since_exit + 6'h01;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_go;
        zq_go;
    endsequence
    sequence s_end;
        $fell(cal_busy);
    endsequence

    property p_start; s_go |=> cal_busy[*8]; endproperty
    a_start: assert property (p_start) else $error("engine did not start");
    property p_init; s_end and kind == 2'h0 |-> blen == COUNT_WIDTH'(ZQ_INIT_CYCLES); endproperty
    a_init: assert property (p_init) else $error("init window wrong");
    property p_oper; s_end and kind == 2'h1 |-> blen == COUNT_WIDTH'(ZQ_OPER_CYCLES); endproperty
    a_oper: assert property (p_oper) else $error("oper window wrong");
    property p_short; s_end and kind == 2'h2 |-> blen == COUNT_WIDTH'(ZQ_SHORT_CYCLES); endproperty
    a_short: assert property (p_short) else $error("short window wrong");
    property p_quiet; cal_busy |-> cmd == cmd_nop; endproperty
    a_quiet: assert property (p_quiet) else $error("command during calibration");
    property p_no_auto; cmd == cmd_self_refresh_exit |=> !cal_busy[*8]; endproperty
    a_no_auto: assert property (p_no_auto) else $error("calibration on exit");
    property p_exit_wait; s_go |-> since_exit >= 6'h1f; endproperty
    a_exit_wait: assert property (p_exit_wait) else $error("calibration too soon");
    property p_cke; cal_busy |-> cke && $past(cke); endproperty
    a_cke: assert property (p_cke) else $error("clock enable low");
    property p_odt; cal_busy |-> !odt; endproperty
    a_odt: assert property (p_odt) else $error("termination pin high");
    property p_hiz; cal_busy |-> !dq_out_en_ctrl && !dq_out_en_dev; endproperty
    a_hiz: assert property (p_hiz) else $error("data pins driven");
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import zq_cal_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  rstn = 1'b0;
    logic [5:0]            req = 6'h00;
    logic [CODE_WIDTH-1:0] ref_code = 8'h90;
    logic                  nom_on = 1'b1;
    logic [PARK_WIDTH-1:0] park = 3'h5;
    logic                  ready, calibrating, first_long_issued, cal_current_on, first_long_seen;
    logic [CODE_WIDTH-1:0] io_code;
    logic [PARK_WIDTH-1:0] applied_term;
    int                    n_fail = 0;
    int                    cmp_count = 0;
    int                    cyc = 0;

    zq_link_if i_zq_link_if();
    zq_cal_controller i_zq_cal_controller(.sys_clk(sys_clk), .rstn(rstn), .req_long(req[0]),
        .req_short(req[1]), .req_precharge(req[2]), .req_sr_enter(req[3]), .req_sr_exit(req[4]),
        .req_other(req[5]), .ready(ready), .calibrating(calibrating),
        .first_long_issued(first_long_issued), .link(i_zq_link_if.controller));
    zq_cal_device i_zq_cal_device(.sys_clk(sys_clk), .rstn(rstn), .link(i_zq_link_if.device),
        .park_value(park), .nominal_term_on(nom_on), .reference_code(ref_code), .io_code(io_code),
        .applied_term(applied_term), .cal_current_on(cal_current_on), .first_long_seen(first_long_seen));
    zq_cal_assertions i_zq_cal_assertions(.sys_clk(sys_clk), .rstn(rstn), .cmd(i_zq_link_if.cmd),
        .cke(i_zq_link_if.cke), .odt(i_zq_link_if.odt), .dq_out_en_ctrl(i_zq_link_if.dq_out_en_ctrl),
        .dq_out_en_dev(i_zq_link_if.dq_out_en_dev), .cal_busy(i_zq_link_if.cal_busy));

    always #25 sys_clk = ~sys_clk;

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // hold a request until taken, then look at the command on the link
    task automatic do_req(input int k, input zq_cmd_t c);
        int n;
        n = 0;
        req[k] <= 1'b1;
        @(posedge sys_clk);
        while (!(ready === 1'b1 || k == 4) && n < 2000)
        begin
            n++;
            @(posedge sys_clk);
        end
        req[k] <= 1'b0;
        @(negedge sys_clk);
        check(11'(i_zq_link_if.cmd), 11'(c));
        @(posedge sys_clk);
    endtask

    task automatic wait_cal(input int exp);
        int n;
        n = 0;
        while (calibrating === 1'b1 && n < 2000)
        begin
            n++;
            if (n == 10)
                check(11'({i_zq_link_if.odt, i_zq_link_if.dq_out_en_dev, i_zq_link_if.cke}), 11'h001);
            @(posedge sys_clk);
        end
        check(11'(n), 11'(exp));
        repeat (3) @(posedge sys_clk);
    endtask

    // count the cycles in which the controller holds requests off
    task automatic wait_ready(input int exp);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 2000)
        begin
            n++;
            @(posedge sys_clk);
        end
        check(11'(n), 11'(exp));
    endtask

    task automatic cal(input int k, input zq_cmd_t c, input logic [7:0] code, input int exp);
        ref_code <= code;
        do_req(2, cmd_precharge_all);
        wait_ready(PRECHARGE_CYCLES);
        do_req(k, c);
        wait_cal(exp);
        check(11'(io_code), 11'(code));
        check(11'({cal_current_on, applied_term}), 11'({1'b0, park}));
    endtask

    task automatic t_first();
        check(11'({first_long_issued, first_long_seen, io_code}), 11'(CODE_RESET));
        cal(0, cmd_zq_long, 8'h90, ZQ_INIT_CYCLES);
        check(11'({first_long_issued, first_long_seen}), 11'h003);
        cal(0, cmd_zq_long, 8'h70, ZQ_OPER_CYCLES);
        cal(1, cmd_zq_short, 8'haf, ZQ_SHORT_CYCLES);
    endtask

    // calibration without precharge is held off
    task automatic t_refuse();
        int n;
        n = 0;
        do_req(5, cmd_other);
        req[0] <= 1'b1;
        repeat (24)
        begin
            @(posedge sys_clk);
            n += (calibrating !== 1'b0);
        end
        req[0] <= 1'b0;
        check(11'(n), 11'h000);
    endtask

    task automatic t_self_refresh();
        do_req(3, cmd_self_refresh_enter);
        check(11'(i_zq_link_if.cke), 11'h000);
        do_req(4, cmd_self_refresh_exit);
        wait_ready(SELF_REFRESH_EXIT_CYCLES);
        check(11'({cal_current_on, i_zq_link_if.cke, io_code}), 11'h1af);
        park <= 3'h3;
        cal(1, cmd_zq_short, 8'hb0, ZQ_SHORT_CYCLES);
    endtask

    // a second reset clears both first-calibration flags
    task automatic t_reset();
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check(11'({first_long_issued, first_long_seen, io_code}), 11'(CODE_RESET));
        cal(0, cmd_zq_long, 8'h8c, ZQ_INIT_CYCLES);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_first();
        t_refuse();
        t_self_refresh();
        t_reset();
        give_verdict();
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            give_verdict();
        end
    end
endmodule
`default_nettype wire
